/* File: src/adc_input_ref_clock_select.sv */
// Channel, reference and conversion clock control for the converter front
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RL1 - The channel field routes pins 0 to 34 in order, or ground, temperature, DAC and fixed reference at 60 to 63.
// RL2 - Codes 35 to 59 connect no input to the sample-and-hold.
// RL3 - Software waits a settling time after a channel change before starting a conversion.
// RL4 - Software may discharge the hold capacitor via a grounded channel such as the DAC at level zero.
// RL5 - The positive reference picks external pin, supply, or fixed 1.024, 2.048 or 4.096 V.
// RL6 - One bit picks the external negative reference pin or ground.
// RL7 - Source bit 1 uses the internal fixed clock, 0 the divided system clock.
// RL8 - Divider code n divides the system clock by 2*(n+1).
// RL9 - A conversion lasts 11.5 bit-clock periods.
// RL10 - Control logic runs on the selected conversion clock, so writes may lag with the internal clock.
// RL11 - The derived clock follows system clock changes; the internal clock does not.
// RL12 - Software selects the internal clock for conversions during sleep.
// RL13 - Channel and reference settings are synchronised into the conversion clock domain before use; clock settings are used directly.
module adc_input_ref_clock_select
  import adc_front_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [7:0]      reg_rdata,
  // Internal fixed oscillator clock; each of its edges marks a half period
  input  wire logic       internal_fixed_rc_clock,
  // Conversion request
  input  wire logic       conv_start,
  // Analog routing and status
  output route_t          route,
  output logic            conv_clock,
  output logic            bit_tick,
  output logic            conv_busy,
  output logic            conv_done
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } state_t;

  ctrl_t      ctrl;
  ctrl_t      ctrl_meta;
  ctrl_t      ctrl_sync;
  logic [1:0] rc_sync;
  logic       rc_prev;
  logic       div_tick;
  logic       start_pend;
  logic [4:0] half_count;
  state_t     state;

  function automatic route_t decode_route(input ctrl_t c);
    route_t r;
    r = '0;
    r.channel     = c.input_channel_select;
    r.pin_channel = (c.input_channel_select <= CH_LAST_PIN); // [RL1]
    r.channel_valid = r.pin_channel || (c.input_channel_select >= CH_GROUND); // [RL1] [RL2]
    r.pos_ref     = (c.pos_ref_select > PREF_4V096) ? PREF_EXT : c.pos_ref_select; // [RL5]
    r.neg_ref_ext = c.neg_ref_select; // [RL6]
    return r;
  endfunction

  // Register writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl <= '{CH_RESET, PREF_EXT, 1'b0, 1'b0, DIV_RESET};
    end else if (ce && reg_write) begin
      unique case (reg_addr)
        ADDR_CHANNEL: ctrl.input_channel_select <= reg_wdata[5:0];
        ADDR_REF: begin
          ctrl.pos_ref_select <= reg_wdata[2:0];
          ctrl.neg_ref_select <= reg_wdata[4];
        end
        ADDR_CLOCK: begin
          ctrl.clock_divider_select     <= reg_wdata[5:0];
          ctrl.conv_clock_source_select <= reg_wdata[7];
        end
        default: ;
      endcase
    end
  end

  // Register reads, data one cycle later; unmapped reads return zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (reg_read) begin
        unique case (reg_addr)
          ADDR_CHANNEL: reg_rdata <= {2'b00, ctrl.input_channel_select};
          ADDR_REF:     reg_rdata <= {3'b000, ctrl.neg_ref_select, 1'b0, ctrl.pos_ref_select};
          ADDR_CLOCK:   reg_rdata <= {ctrl.conv_clock_source_select, 1'b0, ctrl.clock_divider_select};
          ADDR_STATUS:  reg_rdata <= {5'h00, route.channel_valid, conv_done, conv_busy};
          default:      reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Oscillator tick synchroniser; first stage read only by the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rc_sync <= 2'b00;
      rc_prev <= 1'b0;
    end else if (ce) begin
      rc_sync <= {rc_sync[0], internal_fixed_rc_clock};
      rc_prev <= rc_sync[1];
    end
  end

  clock_divider u_div (
    .clk_sys              (clk_sys),
    .rst                  (rst),
    .ce                   (ce),
    .clock_divider_select (ctrl.clock_divider_select),
    .half_tick            (div_tick)
  );

  // Internal clock runs at its own rate, immune to system clock changes
  assign bit_tick = ctrl.conv_clock_source_select ? (ce && (rc_sync[1] != rc_prev)) : div_tick; // [RL7] [RL11]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      conv_clock <= 1'b0;
    end else if (bit_tick) begin
      conv_clock <= ~conv_clock; // [RL7]
    end
  end

  // Settings move into the conversion domain only on bit-clock edges,
  // two stages deep, which is why writes lag with the slow clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_meta <= '{CH_RESET, PREF_EXT, 1'b0, 1'b0, DIV_RESET};
      ctrl_sync <= '{CH_RESET, PREF_EXT, 1'b0, 1'b0, DIV_RESET};
    end else if (bit_tick) begin
      ctrl_meta <= ctrl;      // [RL13] [RL10]
      ctrl_sync <= ctrl_meta; // [RL13]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Reset settings select pin 0, so the route shows it from the start
      route <= '{1'b1, CH_RESET, 1'b1, PREF_EXT, 1'b0};
    end else if (bit_tick) begin
      route <= decode_route(ctrl_sync); // [RL1] [RL2] [RL5] [RL6] [RL13]
    end
  end

  // Start request held until the conversion clock picks it up
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      start_pend <= 1'b0;
    end else if (ce) begin
      if (conv_start) begin
        start_pend <= 1'b1;
      end else if (bit_tick && state == ST_IDLE) begin
        start_pend <= 1'b0; // [RL10]
      end
    end
  end

  // Sequencer counts 23 half periods, i.e. 11.5 bit periods
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state      <= ST_IDLE;
      half_count <= 5'h00;
      conv_done  <= 1'b0;
    end else if (ce) begin
      conv_done <= 1'b0;
      if (bit_tick) begin
        unique case (state)
          ST_IDLE: begin
            if (start_pend) begin
              state      <= ST_CONV;
              half_count <= 5'h00;
            end
          end
          ST_CONV: begin
            if (half_count == CONV_HALF_PERIODS - 5'h01) begin
              state     <= ST_IDLE; // [RL9]
              conv_done <= 1'b1;
            end else begin
              half_count <= half_count + 5'h01;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  assign conv_busy = (state == ST_CONV);

  AST_RESERVED_OPEN: assert property (@(posedge clk_sys) disable iff (rst)
    (route.channel > CH_LAST_PIN && route.channel < CH_GROUND) |-> !route.channel_valid) // [RL2]
    else $error("reserved channel must connect nothing");
  AST_PIN_ROUTE: assert property (@(posedge clk_sys) disable iff (rst)
    (route.channel <= CH_LAST_PIN) |-> (route.pin_channel && route.channel_valid)) // [RL1]
    else $error("pin channel not routed");
  AST_SPECIAL_ROUTE: assert property (@(posedge clk_sys) disable iff (rst)
    (route.channel >= CH_GROUND) |-> (route.channel_valid && !route.pin_channel)) // [RL1]
    else $error("internal channel misrouted");
  AST_POS_REF: assert property (@(posedge clk_sys) disable iff (rst)
    route.pos_ref <= PREF_4V096) // [RL5]
    else $error("positive reference out of range");
  AST_NEG_REF: assert property (@(posedge clk_sys) disable iff (rst)
    (bit_tick && ctrl_sync.neg_ref_select) |=> route.neg_ref_ext) // [RL6]
    else $error("negative reference not applied");
  AST_CLK_TOGGLE: assert property (@(posedge clk_sys) disable iff (rst)
    (bit_tick && !rst) |=> (conv_clock != $past(conv_clock))) // [RL7]
    else $error("conversion clock did not toggle");
  AST_DONE_END: assert property (@(posedge clk_sys) disable iff (rst)
    conv_done |-> ($past(conv_busy) && !conv_busy)) // [RL9]
    else $error("done without finishing conversion");
  AST_SYNC_LAG: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(ctrl_sync) |-> $past(bit_tick)) // [RL13]
    else $error("settings crossed without a conversion clock edge");
endmodule
`default_nettype wire

/* File: inc/adc_front_pkg.sv */
// Constants and carrier types for the converter front control block
package adc_front_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [7:0] ADDR_CHANNEL = 8'h00;
  localparam logic [7:0] ADDR_REF     = 8'h04;
  localparam logic [7:0] ADDR_CLOCK   = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0c;
  localparam logic [5:0] CH_FIXED_REF = 6'h3f;
  localparam logic [5:0] CH_DAC       = 6'h3e;
  localparam logic [5:0] CH_TEMP      = 6'h3d;
  localparam logic [5:0] CH_GROUND    = 6'h3c;
  localparam logic [5:0] CH_LAST_PIN  = 6'h22;
  localparam logic [5:0] CH_RESET     = 6'h00;
  localparam logic [2:0] PREF_EXT     = 3'h0;
  localparam logic [2:0] PREF_SUPPLY  = 3'h1;
  localparam logic [2:0] PREF_1V024   = 3'h2;
  localparam logic [2:0] PREF_2V048   = 3'h3;
  localparam logic [2:0] PREF_4V096   = 3'h4;
  localparam logic [5:0] DIV_RESET    = 6'h00;
  // Half periods of the bit clock per conversion: 11.5 periods
  localparam logic [4:0] CONV_HALF_PERIODS = 5'h17;
  localparam int unsigned SYNC_STAGES = 2;

  typedef struct packed {
    logic [5:0] input_channel_select;
    logic [2:0] pos_ref_select;
    logic       neg_ref_select;
    logic       conv_clock_source_select;
    logic [5:0] clock_divider_select;
  } ctrl_t;

  typedef struct packed {
    logic       channel_valid;
    logic [5:0] channel;
    logic       pin_channel;
    logic [2:0] pos_ref;
    logic       neg_ref_ext;
  } route_t;
endpackage

/* File: src/clock_divider.sv */
// Divider that makes the system-derived bit clock enable
`timescale 1ns/1ns
`default_nettype none
module clock_divider
  import adc_front_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       ce,
  // Division control
  input  wire logic [5:0] clock_divider_select,
  // Half-period tick of the divided clock
  output logic            half_tick
);
  logic [5:0] count;

  // Ticking every n+1 cycles gives a full period of 2*(n+1)
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count <= 6'h00;
    end else if (ce) begin
      if (count >= clock_divider_select) begin
        count <= 6'h00; // [RL8]
      end else begin
        count <= count + 6'h01;
      end
    end
  end

  assign half_tick = ce && (count >= clock_divider_select); // [RL8] [RL11]

  AST_DIV_PERIOD: assert property (@(posedge clk_sys) disable iff (rst)
    (half_tick && ce && clock_divider_select == 6'h00) ##1 (ce && clock_divider_select == 6'h00) |-> half_tick) // [RL8]
    else $error("divide-by-2 must tick every cycle");
endmodule
`default_nettype wire

/* File: sim/adc_input_ref_clock_select_tb.sv */
// Self-checking bench for the converter front control block
`timescale 1ns/1ns
`default_nettype none
module adc_input_ref_clock_select_tb;
  import adc_front_pkg::*;
  logic       clk_sys    = 1'b0;
  logic       rst        = 1'b1;
  logic       ce         = 1'b1;
  logic       reg_write  = 1'b0;
  logic       reg_read   = 1'b0;
  logic       rc         = 1'b0;
  logic       conv_start = 1'b0;
  logic       rd_seen    = 1'b0;
  logic [7:0] reg_addr   = 8'h00;
  logic [7:0] reg_wdata  = 8'h00;
  logic [7:0] reg_rdata;
  logic       conv_clock;
  logic       bit_tick;
  logic       conv_busy;
  logic       conv_done;
  logic       cv;
  route_t     route;
  route_t     er;
  logic [7:0] exp_q[$];
  // Ground and DAC codes double as the hold capacitor discharge path
  logic [5:0] chs[9] = '{6'h00, 6'h22, 6'h23, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f, 6'h00};
  logic [5:0] ds[4]  = '{6'h00, 6'h01, 6'h05, 6'h3f};
  int         failures = 0;
  int         n_tests  = 0;
  int         cnt;

  adc_input_ref_clock_select u_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .internal_fixed_rc_clock(rc), .conv_start(conv_start), .route(route), .conv_clock(conv_clock),
    .bit_tick(bit_tick), .conv_busy(conv_busy), .conv_done(conv_done));

  initial forever #5 clk_sys = ~clk_sys;
  // Internal oscillator stand-in, toggling every 7 system cycles
  always begin
    repeat (7) @(posedge clk_sys);
    rc <= ~rc;
  end

  task automatic fail(input string m);
    failures++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) fail("value");
  endtask
  task automatic chk_route();
    n_tests++;
    if (route !== er) fail("route");
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
  endtask
  // Counts ticks; one extra beyond the two sync stages and the route register covers the write edge
  task automatic tick_wait(input int n);
    cnt = 0;
    while (cnt < n) begin
      @(posedge clk_sys);
      if (bit_tick === 1'b1) cnt++;
    end
    #1;
  endtask
  task automatic tick_gap();
    cnt = 0;
    do begin
      @(posedge clk_sys);
      cnt++;
    end while (bit_tick !== 1'b1);
    #1;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen) begin
      n_tests++;
      if (reg_rdata !== exp_q[0]) fail("read data");
      void'(exp_q.pop_front());
    end
    rd_seen = reg_read;
  end

  initial begin
    #800000;
    failures++;
    summarize();
  end

  initial begin
    void'($urandom(69));
    chs[8] = 6'($urandom_range(34, 0));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_CHANNEL, 8'h00);
    rd(ADDR_CLOCK, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    $display("test reset and unmapped done");
    er = '0;
    foreach (chs[i]) begin
      wr(ADDR_CHANNEL, {2'h0, chs[i]});
      rd(ADDR_CHANNEL, {2'h0, chs[i]});
      tick_wait(4);
      er.channel       = chs[i];
      er.pin_channel   = chs[i] <= CH_LAST_PIN;
      er.channel_valid = chs[i] <= CH_LAST_PIN || chs[i] >= CH_GROUND;
      chk_route();
    end
    $display("test channels done");
    for (int p = 0; p < 8; p++) begin
      wr(ADDR_REF, {3'h0, 1'(p), 1'b0, 3'(p)});
      tick_wait(4);
      er.pos_ref     = p > 4 ? PREF_EXT : 3'(p);
      er.neg_ref_ext = 1'(p);
      chk_route();
    end
    $display("test references done");
    foreach (ds[i]) begin
      wr(ADDR_CLOCK, {2'h0, ds[i]});
      rd(ADDR_CLOCK, {2'h0, ds[i]});
      tick_wait(5);
      cv = conv_clock;
      tick_gap();
      chk(cnt, 32'(ds[i]) + 1);
      chk(conv_clock, !cv);
    end
    $display("test divider done");
    for (int d = 0; d < 2; d++) begin
      wr(ADDR_CLOCK, 8'(d));
      tick_wait(4);
      @(posedge clk_sys);
      conv_start <= 1'b1;
      @(posedge clk_sys);
      conv_start <= 1'b0;
      #1;
      while (conv_busy !== 1'b1) begin
        @(posedge clk_sys);
        #1;
      end
      cnt = 0;
      while (conv_done !== 1'b1) begin
        @(posedge clk_sys);
        #1;
        cnt++;
      end
      chk(cnt, 23 * (d + 1));
    end
    rd(ADDR_STATUS, 8'h04);
    $display("test conversion done");
    wr(ADDR_CLOCK, 8'h80);
    rd(ADDR_CLOCK, 8'h80);
    tick_wait(5);
    tick_gap();
    chk(cnt, 7);
    wr(ADDR_CHANNEL, 8'h05);
    #1;
    chk_route();
    tick_wait(4);
    er.channel       = 6'h05;
    er.pin_channel   = 1'b1;
    er.channel_valid = 1'b1;
    chk_route();
    $display("test internal clock done");
    @(posedge clk_sys);
    ce <= 1'b0;
    #1;
    cv = conv_clock;
    cnt = 0;
    repeat (20) begin
      @(posedge clk_sys);
      #1;
      if (bit_tick !== 1'b0) cnt++;
    end
    chk(cnt, 0);
    chk(conv_clock, cv);
    @(posedge clk_sys);
    ce <= 1'b1;
    $display("test clock enable done");
    repeat (3) @(posedge clk_sys);
    summarize();
  end
endmodule
`default_nettype wire
